// >>> design/efx_mac.v
// Purpose: frame-level transmit and receive engine of a 10 Mb/s MAC
// Assumes: pclk 125 MHz, bit enable divided from it; byte streams from a FIFO on tx, to a FIFO on rx
// Notes: serial line side is one bit per bit-time, MSB of each byte last (LSB first on the wire)
`include "efx_map.vh"
module efx_mac #(
  parameter CLK_PER_BIT = `EFX_CLK_PER_BIT
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_last,
  input wire tx_sop,
  output reg tx_ready,
  output reg tx_rewind,
  output reg tx_commit,
  output reg tx_skip,
  output reg tx_out,
  output reg tx_en,
  input wire carrier_in,
  input wire coll_in,
  input wire rx_in,
  input wire rx_dv,
  input wire jabber_in,
  input wire link_fail_in,
  output reg [7:0] rx_data,
  output reg rx_wr,
  output reg rx_end,
  output reg rx_drop,
  output reg [1:0] rx_watermark,
  output reg fault_summary,
  output reg host_interrupt_line
);
// ****************************************
// Pin synchronisers and bit enable
// ****************************************
reg [2:0] s_crs, s_col, s_rxd, s_rdv, s_jab, s_lf;
reg crs, col, rxd, rdv, jab, lf;
reg [7:0] divc;
reg bit_en;
always @(posedge pclk or negedge presetn)
  if (!presetn)
  begin
    s_crs <= 3'h0; s_col <= 3'h0; s_rxd <= 3'h0; s_rdv <= 3'h0; s_jab <= 3'h0; s_lf <= 3'h0;
    crs <= 1'b0; col <= 1'b0; rxd <= 1'b0; rdv <= 1'b0; jab <= 1'b0; lf <= 1'b0;
    divc <= 8'h00; bit_en <= 1'b0;
  end
  else
  begin
    s_crs <= {s_crs[1:0], carrier_in};
    s_col <= {s_col[1:0], coll_in};
    s_rxd <= {s_rxd[1:0], rx_in};
    s_rdv <= {s_rdv[1:0], rx_dv};
    s_jab <= {s_jab[1:0], jabber_in};
    s_lf <= {s_lf[1:0], link_fail_in};
    // Level changes only once the two later stages agree
    if (s_crs[2] == s_crs[1]) crs <= s_crs[2];
    if (s_col[2] == s_col[1]) col <= s_col[2];
    if (s_rxd[2] == s_rxd[1]) rxd <= s_rxd[2];
    if (s_rdv[2] == s_rdv[1]) rdv <= s_rdv[2];
    if (s_jab[2] == s_jab[1]) jab <= s_jab[2];
    if (s_lf[2] == s_lf[1]) lf <= s_lf[2];
    bit_en <= (divc == CLK_PER_BIT[7:0] - 8'h01);
    divc <= (divc == CLK_PER_BIT[7:0] - 8'h01) ? 8'h00 : divc + 8'h01;
  end
// ****************************************
// CRC step, one bit, reflected input
// ****************************************
function [31:0] crc_bit;
  input [31:0] c;
  input b;
  begin
    crc_bit = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? `EFX_CRC_POLY : 32'h0);
  end
endfunction
// ****************************************
// Registers
// ****************************************
reg [31:0] ctrl;
reg retry_exhausted_flag_f, carrier_lost_flag_f, late_collision_flag_f, heartbeat_missing_flag_f, crc_f, txdone_f, rxdone_f, rxdel_f;
wire dxfcs = ctrl[`EFX_B_DXFCS];
wire apad = ctrl[`EFX_B_APAD];
wire accept_all_frames = ctrl[`EFX_B_ACCEPT_ALL_FRAMES];
wire runt_accept = ctrl[`EFX_B_RPA];
wire tpm = ctrl[`EFX_B_TPMODE];
wire nobc = ctrl[`EFX_B_NOBCAST];
wire astrp = ctrl[`EFX_B_ASTRP];
wire [31:0] stat = {23'h0, rxdel_f, rxdone_f, txdone_f, crc_f, heartbeat_missing_flag_f, heartbeat_missing_flag_f, late_collision_flag_f, carrier_lost_flag_f, retry_exhausted_flag_f};
wire acc = psel & penable;
wire wr_stat = acc & pwrite & (paddr == `EFX_OFF_STAT);
// Set events from engines, one-cycle pulses
reg ev_retry_exhausted_flag, ev_carrier_lost_flag, ev_late_collision_flag, ev_heartbeat_missing_flag, ev_crc, ev_txdone, ev_rxdone, ev_rxdel;
// ****************************************
// Transmit engine
// ****************************************
localparam T_IDLE = 3'h0, T_PRE = 3'h1, T_DATA = 3'h2, T_PAD = 3'h3, T_FCS = 3'h4, T_JAM = 3'h5,
  T_SQE = 3'h6, T_FLUSH = 3'h7;
reg [2:0] ts;
reg [7:0] tsh;
reg [2:0] tbit;
reg [15:0] tbits;
reg [31:0] tcrc;
reg [4:0] tries;
reg [5:0] fcnt;
reg add_fcs, tlast, saw_crs, crs_drop, tx_collided;
reg [7:0] bw;
always @(posedge pclk or negedge presetn)
  if (!presetn)
  begin
    ts <= T_IDLE; tsh <= 8'h00; tbit <= 3'h0; tbits <= 16'h0; tcrc <= 32'hffff_ffff; tries <= 5'h0;
    fcnt <= 6'h0; add_fcs <= 1'b0; tlast <= 1'b0; saw_crs <= 1'b0; crs_drop <= 1'b0; tx_collided <= 1'b0;
    bw <= 8'h00; tx_ready <= 1'b0; tx_rewind <= 1'b0; tx_commit <= 1'b0; tx_skip <= 1'b0;
    tx_out <= 1'b0; tx_en <= 1'b0; ev_retry_exhausted_flag <= 1'b0; ev_carrier_lost_flag <= 1'b0; ev_late_collision_flag <= 1'b0; ev_heartbeat_missing_flag <= 1'b0;
    ev_txdone <= 1'b0;
  end
  else
  begin
    tx_ready <= 1'b0; tx_rewind <= 1'b0; tx_commit <= 1'b0; tx_skip <= 1'b0;
    ev_retry_exhausted_flag <= 1'b0; ev_carrier_lost_flag <= 1'b0; ev_late_collision_flag <= 1'b0; ev_heartbeat_missing_flag <= 1'b0; ev_txdone <= 1'b0;
    case (ts)
      T_IDLE:
        if (tx_valid && bit_en)
        begin
          // First preamble bit goes out here, so the count starts at one
          ts <= T_PRE; tbits <= 16'h1; tbit <= 3'h0; tcrc <= 32'hffff_ffff;
          add_fcs <= apad | ~dxfcs;
          saw_crs <= 1'b0; crs_drop <= 1'b0; tx_en <= 1'b1; tx_out <= 1'b1;
        end
      T_PRE:
        if (bit_en)
        begin
          tbits <= tbits + 16'h1;
          tx_out <= (tbits == 16'd63) ? 1'b1 : ~tx_out;
          if (tbits == 16'd63)
          begin
            ts <= T_DATA; tsh <= tx_data; tlast <= tx_last; tx_ready <= 1'b1; tbit <= 3'h0;
          end
        end
      T_DATA, T_PAD, T_FCS:
        if (bit_en)
        begin
          tbits <= tbits + 16'h1;
          if (ts == T_FCS)
          begin
            tx_out <= ~tcrc[31];
            tcrc <= {tcrc[30:0], 1'b1};
          end
          else
          begin
            tx_out <= tsh[0];
            tcrc <= crc_bit(tcrc, tsh[0]);
            tsh <= {1'b0, tsh[7:1]};
          end
          tbit <= tbit + 3'h1;
          if (tbit == 3'h7)
          begin
            if (ts == T_FCS && fcnt == 6'd3)
              ts <= T_SQE;
            else if (ts == T_FCS)
              fcnt <= fcnt + 6'h1;
            else if (ts == T_DATA && !tlast)
            begin
              tsh <= tx_data; tlast <= tx_last; tx_ready <= 1'b1;
            end
            else if (apad && tbits + 16'h1 < `EFX_PAD_BITS)
            begin
              ts <= T_PAD; tsh <= 8'h00;
            end
            else if (add_fcs)
            begin
              ts <= T_FCS; fcnt <= 6'h0;
            end
            else
              ts <= T_SQE;
          end
          if (tbits == `EFX_SLOT_BITS - 1)
            tx_commit <= 1'b1;
          if (crs) saw_crs <= 1'b1;
          else if (saw_crs) crs_drop <= 1'b1;
          if (col)
          begin
            ts <= T_JAM; bw <= 8'd32; tx_collided <= (tbits < `EFX_SLOT_BITS);
          end
        end
      T_JAM:
        if (bit_en)
        begin
          tx_out <= ~tx_out;
          bw <= bw - 8'h1;
          if (bw == 8'h1)
          begin
            tx_en <= 1'b0;
            if (!tx_collided)
            begin
              ev_late_collision_flag <= 1'b1; ts <= T_FLUSH; tries <= 5'h0;
            end
            else if (tries == `EFX_MAX_TRIES - 1)
            begin
              ev_retry_exhausted_flag <= 1'b1; ts <= T_FLUSH; tries <= 5'h0;
            end
            else
            begin
              tries <= tries + 5'h1; tx_rewind <= 1'b1; ts <= T_IDLE;
            end
          end
        end
      T_SQE:
      begin
        if (bit_en)
        begin
          if (bw == 8'h0)
          begin
            // Last bit has now stood a full bit time
            tx_en <= 1'b0; tx_out <= 1'b0;
            bw <= 8'h1; tries <= 5'h0; tx_commit <= 1'b1; ev_txdone <= 1'b1;
            if ((!tpm && (!saw_crs || crs_drop)) || (tpm && (jab || lf)))
              ev_carrier_lost_flag <= 1'b1;
            fcnt <= 6'h0;
          end
          else
          begin
            fcnt <= fcnt + 6'h1;
            if (!tpm && col)
            begin
              ts <= T_IDLE; bw <= 8'h0;
            end
            else if (tpm || fcnt == `EFX_SQE_BITS - 1)
            begin
              ev_heartbeat_missing_flag <= ~tpm | lf;
              ts <= T_IDLE; bw <= 8'h0;
            end
          end
        end
      end
      T_FLUSH:
      begin
        // Drop rest of failed frame up to next start marker
        if (tx_valid && tx_sop && !tx_ready)
        begin
          ts <= T_IDLE; bw <= 8'h0;
        end
        else if (tx_valid && !tx_ready)
          tx_skip <= 1'b1;
        tx_ready <= tx_valid & ~tx_sop & ~tx_ready;
      end
      default: ts <= T_IDLE;
    endcase
  end
// ****************************************
// Receive engine
// ****************************************
reg [15:0] rbits, rbytes, rlen;
reg [7:0] rsh;
reg [2:0] rbit;
reg [31:0] rcrc;
reg rsync, ractive, rcol, rbcast, rdv_q;
reg [7:0] rhold [0:3];
reg [2:0] rfill;
always @(posedge pclk or negedge presetn)
  if (!presetn)
  begin
    rbits <= 16'h0; rbytes <= 16'h0; rlen <= 16'hffff; rsh <= 8'h00; rbit <= 3'h0; rcrc <= 32'hffff_ffff;
    rsync <= 1'b0; ractive <= 1'b0; rcol <= 1'b0; rbcast <= 1'b1; rdv_q <= 1'b0; rfill <= 3'h0;
    rhold[0] <= 8'h0; rhold[1] <= 8'h0; rhold[2] <= 8'h0; rhold[3] <= 8'h0;
    rx_data <= 8'h00; rx_wr <= 1'b0; rx_end <= 1'b0; rx_drop <= 1'b0;
    ev_crc <= 1'b0; ev_rxdone <= 1'b0; ev_rxdel <= 1'b0;
  end
  else
  begin
    rx_wr <= 1'b0; rx_end <= 1'b0; rx_drop <= 1'b0; ev_crc <= 1'b0; ev_rxdone <= 1'b0; ev_rxdel <= 1'b0;
    if (bit_en)
    begin
      rdv_q <= rdv;
      if (rdv && !rsync)
      begin
        rsh <= {rxd, rsh[7:1]};
        if (rsh[7] && rxd)
        begin
          rsync <= 1'b1; rbit <= 3'h0; rbits <= 16'h0; rbytes <= 16'h0; rcrc <= 32'hffff_ffff;
          rcol <= 1'b0; rbcast <= 1'b1; rfill <= 3'h0; rlen <= 16'hffff;
        end
      end
      else if (rdv && rsync)
      begin
        rsh <= {rxd, rsh[7:1]};
        rcrc <= crc_bit(rcrc, rxd);
        rbits <= rbits + 16'h1;
        rbit <= rbit + 3'h1;
        if (col && rbits < `EFX_SLOT_BITS) rcol <= 1'b1;
        if (rbit == 3'h7)
        begin
          rbytes <= rbytes + 16'h1;
          if (rbytes < 16'd6 && {rxd, rsh[7:1]} != 8'hff) rbcast <= 1'b0;
          if (rbytes == 16'd12) rlen[15:8] <= {rxd, rsh[7:1]};
          if (rbytes == 16'd13) rlen[7:0] <= {rxd, rsh[7:1]};
          // Four-byte delay line so the FCS never reaches the FIFO
          rhold[0] <= {rxd, rsh[7:1]}; rhold[1] <= rhold[0]; rhold[2] <= rhold[1]; rhold[3] <= rhold[2];
          if (rfill != 3'h4) rfill <= rfill + 3'h1;
          else if (!(astrp && rlen < `EFX_MIN_LEN && rbytes >= rlen + 16'd18))
          begin
            rx_data <= rhold[3]; rx_wr <= 1'b1;
          end
        end
      end
      if (!rdv && rdv_q && rsync)
      begin
        rsync <= 1'b0; rsh <= 8'h00;
        if (rcol || (!runt_accept && rbytes < `EFX_MIN_FRAME) || (nobc && rbcast && !accept_all_frames))
        begin
          rx_drop <= 1'b1; ev_rxdel <= 1'b1;
        end
        else
        begin
          rx_end <= 1'b1; ev_rxdone <= 1'b1; ev_crc <= (rcrc != `EFX_CRC_RESID);
        end
      end
    end
  end
// ****************************************
// APB slave and status
// ****************************************
always @(posedge pclk or negedge presetn)
  if (!presetn)
  begin
    ctrl <= `EFX_CTRL_RST;
    prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
    retry_exhausted_flag_f <= 1'b0; carrier_lost_flag_f <= 1'b0; late_collision_flag_f <= 1'b0; heartbeat_missing_flag_f <= 1'b0; crc_f <= 1'b0;
    txdone_f <= 1'b0; rxdone_f <= 1'b0; rxdel_f <= 1'b0;
    rx_watermark <= 2'h2; fault_summary <= 1'b0; host_interrupt_line <= 1'b0;
  end
  else
  begin
    pready <= psel & ~penable;
    pslverr <= 1'b0;
    if (psel && !penable)
    begin
      pslverr <= (paddr != `EFX_OFF_CTRL) && (paddr != `EFX_OFF_STAT) && (paddr != `EFX_OFF_TXD)
        && (paddr != `EFX_OFF_RXD);
      case (paddr)
        `EFX_OFF_CTRL: prdata <= ctrl;
        `EFX_OFF_STAT: prdata <= stat;
        `EFX_OFF_TXD: prdata <= {27'h0, tries};
        `EFX_OFF_RXD: prdata <= {16'h0000, rlen};
        default: prdata <= 32'h0;
      endcase
    end
    if (acc && pready && pwrite && paddr == `EFX_OFF_CTRL)
      ctrl <= pwdata & `EFX_CTRL_MASK;
    // Write one to clear; a same-cycle set wins
    retry_exhausted_flag_f <= ev_retry_exhausted_flag | (retry_exhausted_flag_f & ~(wr_stat & pready & pwdata[`EFX_B_RETRY_EXHAUSTED_FLAG]));
    carrier_lost_flag_f <= ev_carrier_lost_flag | (carrier_lost_flag_f & ~(wr_stat & pready & pwdata[`EFX_B_CARRIER_LOST_FLAG]));
    late_collision_flag_f <= ev_late_collision_flag | (late_collision_flag_f & ~(wr_stat & pready & pwdata[`EFX_B_LATE_COLLISION_FLAG]));
    heartbeat_missing_flag_f <= ev_heartbeat_missing_flag | (heartbeat_missing_flag_f & ~(wr_stat & pready & pwdata[`EFX_B_HEARTBEAT_MISSING_FLAG]));
    crc_f <= ev_crc | (crc_f & ~(wr_stat & pready & pwdata[`EFX_B_CRC]));
    txdone_f <= ev_txdone | (txdone_f & ~(wr_stat & pready & pwdata[`EFX_B_TXDONE]));
    rxdone_f <= ev_rxdone | (rxdone_f & ~(wr_stat & pready & pwdata[`EFX_B_RXDONE]));
    rxdel_f <= ev_rxdel | (rxdel_f & ~(wr_stat & pready & pwdata[`EFX_B_RXDEL]));
    rx_watermark <= ctrl[`EFX_B_WM_LO+1:`EFX_B_WM_LO];
    fault_summary <= heartbeat_missing_flag_f;
    // Heartbeat loss is deliberately not an interrupt source
    host_interrupt_line <= retry_exhausted_flag_f | carrier_lost_flag_f | late_collision_flag_f | crc_f | txdone_f | rxdone_f;
  end
endmodule

// >>> design/efx_map.vh
// Purpose: register offsets, fields, reset values and timing counts for the frame engine
// Assumes: APB, 32-bit data, word-aligned registers
// Notes: included by efx_mac.v only
`ifndef EFX_MAP_VH
`define EFX_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define EFX_OFF_CTRL 12'h000
`define EFX_OFF_STAT 12'h004
`define EFX_OFF_TXD 12'h008
`define EFX_OFF_RXD 12'h00c
// ****************************************
// Control fields
// ****************************************
`define EFX_B_DXFCS 0
`define EFX_B_APAD 1
`define EFX_B_ACCEPT_ALL_FRAMES 2
`define EFX_B_RPA 3
`define EFX_B_TPMODE 4
`define EFX_B_NOBCAST 5
`define EFX_B_WM_LO 8
`define EFX_B_ASTRP 10
`define EFX_CTRL_RST 32'h0000_0200
`define EFX_CTRL_MASK 32'h0000_073f
// ****************************************
// Status fields
// ****************************************
`define EFX_B_RETRY_EXHAUSTED_FLAG 0
`define EFX_B_CARRIER_LOST_FLAG 1
`define EFX_B_LATE_COLLISION_FLAG 2
`define EFX_B_HEARTBEAT_MISSING_FLAG 3
`define EFX_B_ERR 4
`define EFX_B_CRC 5
`define EFX_B_TXDONE 6
`define EFX_B_RXDONE 7
`define EFX_B_RXDEL 8
// ****************************************
// Timing and pad sizes in bits, minimum frame and length in bytes, bit and clock periods in ns
// ****************************************
`define EFX_SLOT_BITS 512
`define EFX_PAD_BITS 544
`define EFX_SQE_BITS 40
`define EFX_MAX_TRIES 16
`define EFX_MIN_FRAME 64
`define EFX_MIN_LEN 46
`define EFX_BIT_NS 100
`define EFX_CLK_NS 8
`define EFX_CLK_PER_BIT ((`EFX_BIT_NS + `EFX_CLK_NS - 1) / `EFX_CLK_NS)
`define EFX_CRC_POLY 32'h04c1_1db7
`define EFX_CRC_RESID 32'hc704_dd7b
`endif

// >>> sim/efx_mac_assertions.sv
// Purpose: port-level checks for the frame engine
// Assumes: single pclk domain, presetn async active low
// Notes: attached to efx_mac by the bind at the foot
module efx_chk #(
  parameter CLK_PER_BIT = 13
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire pslverr,
  input wire tx_en,
  input wire coll_in,
  input wire tx_rewind,
  input wire tx_commit,
  input wire rx_end,
  input wire rx_drop,
  input wire [1:0] rx_watermark,
  input wire fault_summary
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  int unsigned txc;
  int unsigned idle;
  logic coll_seen;
  wire wr_done = psel && penable && pwrite && pready;
  // ******
  // Attempt length and gap since it
  // ******
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txc <= 0;
      idle <= 0;
      coll_seen <= 1'b0;
    end
    else
    begin
      idle <= tx_en ? 0 : idle + 1;
      if (tx_en)
        txc <= (idle != 0) ? 1 : txc + 1;
      if (tx_en && idle != 0)
        coll_seen <= 1'b0;
      else if (coll_in)
        coll_seen <= 1'b1;
    end
  end
  // ******
  // Properties
  // ******
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  a_wm_reset: assert property ($rose(presetn) |-> rx_watermark == 2'b10)
    else $error("watermark reset value wrong");
  a_wm_by_write: assert property ($changed(rx_watermark) |-> $past(wr_done, 2))
    else $error("watermark moved without write");
  a_retry_cause: assert property (tx_rewind |-> coll_seen)
    else $error("rewind without collision");
  a_no_late_retry: assert property (tx_rewind |-> txc < 560 * CLK_PER_BIT)
    else $error("late attempt was retried");
  a_commit_excl: assert property (!(tx_commit && tx_rewind))
    else $error("commit and rewind together");
  a_rx_excl: assert property (!(rx_end && rx_drop))
    else $error("frame both ended and dropped");
  a_sqe_wait: assert property ($rose(fault_summary) |-> !tx_en && idle >= 39 * CLK_PER_BIT)
    else $error("heartbeat fault before window end");
  c_retry: cover property (tx_rewind);
  c_drop: cover property (rx_drop);
  c_fault: cover property ($rose(fault_summary));
endmodule

bind efx_mac efx_chk #(.CLK_PER_BIT(CLK_PER_BIT)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .pslverr, .tx_en, .coll_in, .tx_rewind, .tx_commit, .rx_end, .rx_drop, .rx_watermark, .fault_summary);

// >>> sim/efx_phy_model.sv
// Purpose: behavioural transceiver and medium facing the engine
// Assumes: CPB pclk cycles per bit time, as in the engine
// Notes: tb steers loop_car, give_sqe and coll_bit by hierarchy
module efx_phy_model #(
  parameter int CPB = 4
)(
  input wire logic pclk,
  input wire logic tx_en,
  output logic carrier_in,
  output logic coll_in,
  output logic rx_in,
  output logic rx_dv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic loop_car = 1'b1;
  logic give_sqe = 1'b1;
  int coll_bit = 0;
  int on_cnt = 0;
  // Far away, so no heartbeat before the first frame
  int off_cnt = 1000000;
  initial
  begin
    carrier_in = 1'b0;
    coll_in = 1'b0;
    rx_in = 1'b0;
    rx_dv = 1'b0;
  end
  always @(posedge pclk)
  begin
    on_cnt <= tx_en ? on_cnt + 1 : 0;
    off_cnt <= tx_en ? 0 : off_cnt + 1;
    carrier_in <= tx_en && loop_car;
    coll_in <= (tx_en && coll_bit != 0 && on_cnt >= coll_bit * CPB)
      || (give_sqe && off_cnt >= 10 * CPB && off_cnt < 20 * CPB);
  end
  task automatic send_rx(input int n);
    logic [7:0] b;
    for (int i = 0; i < n + 8; i++)
    begin
      b = i < 7 ? 8'h55 : (i == 7 ? 8'hd5 : 8'h3c);
      for (int k = 0; k < 8; k++)
      begin
        @(posedge pclk);
        rx_dv <= 1'b1;
        rx_in <= b[k];
        repeat (CPB - 1) @(posedge pclk);
      end
    end
    @(posedge pclk);
    rx_dv <= 1'b0;
    // Released line must not keep the last bit
    rx_in <= ~rx_in;
  endtask
endmodule

// >>> sim/tb.sv
// Purpose: self-checking bench for the frame engine
// Assumes: short bit time through CLK_PER_BIT
// Notes: register rows first, then frame cases
`define chk(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPB = 4;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic x;} efx_row_t;
  efx_row_t rows [5] = '{'{1'b0, 12'h000, 32'h0, 32'h200, 1'b0},
    '{1'b1, 12'h000, 32'h73f, 32'h0, 1'b0}, '{1'b0, 12'h000, 32'h0, 32'h73f, 1'b0},
    '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1}, '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tx_ready, tx_rewind, tx_commit, tx_skip, tx_out, tx_en;
  logic carrier_in, coll_in, rx_in, rx_dv, rx_wr, rx_end, rx_drop, fault_summary, host_interrupt_line;
  logic jabber_in = 1'b0, link_fail_in = 1'b0;
  logic [7:0] rx_data;
  logic [1:0] rx_watermark;
  int failures = 0, n_tests = 0, cyc = 0, rew = 0, drops = 0, ends = 0, src_len = 0, src_idx = 0;
  wire tx_valid = src_idx < src_len;
  wire [7:0] tx_data = 8'(src_idx + 16);
  wire tx_sop = src_idx == 0;
  wire tx_last = src_idx == src_len - 1;
  efx_mac #(.CLK_PER_BIT(CPB)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_valid, .tx_data, .tx_last, .tx_sop, .tx_ready, .tx_rewind, .tx_commit, .tx_skip,
    .tx_out, .tx_en, .carrier_in, .coll_in, .rx_in, .rx_dv, .jabber_in, .link_fail_in, .rx_data, .rx_wr,
    .rx_end, .rx_drop, .rx_watermark, .fault_summary, .host_interrupt_line);
  efx_phy_model #(.CPB(CPB)) phy (.pclk, .tx_en, .carrier_in, .coll_in, .rx_in, .rx_dv);
  always #4 pclk = ~pclk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ******
  // Byte source, event counts, hang limit
  // ******
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    rew <= rew + tx_rewind;
    drops <= drops + rx_drop;
    ends <= ends + rx_end;
    if (tx_rewind)
      src_idx <= 0;
    else if (tx_ready || tx_skip)
      src_idx <= src_idx + 1;
    if (cyc == 60000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic start(input int n);
    wr(12'h004, 32'h1ff);
    src_idx <= 0;
    src_len <= n;
  endtask
  task automatic measure(output int len, input int rest);
    len = 0;
    wait (tx_en === 1'b1);
    do
    begin
      @(negedge pclk);
      len += (tx_en === 1'b1);
    end
    while (tx_en === 1'b1);
    repeat (rest * CPB) @(posedge pclk);
  endtask
  initial
  begin
    logic [31:0] r;
    logic e;
    int len;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `chk("watermark", 2'b10, rx_watermark)
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      if (!rows[i].w)
        `chk("reg data", rows[i].e, r)
      `chk("slverr", rows[i].x, e)
    end
    $display("register rows done");
    wr(12'h000, 32'h003);
    start(4);
    measure(len, 100);
    `chk("pad bits", 576 * CPB, len)
    rd(12'h004, r);
    `chk("heartbeat", 1'b0, r[3])
    `chk("tx done", 1'b1, r[6])
    $display("pad case done");
    wr(12'h000, 32'h001);
    phy.give_sqe = 1'b0;
    start(60);
    measure(len, 100);
    `chk("no fcs bits", 544 * CPB, len)
    wr(12'h004, 32'h1e7);
    repeat (2) @(negedge pclk);
    `chk("fault summary", 1'b1, fault_summary)
    `chk("irq quiet", 1'b0, host_interrupt_line)
    phy.give_sqe = 1'b1;
    $display("heartbeat case done");
    wr(12'h000, 32'h000);
    phy.loop_car = 1'b0;
    start(60);
    measure(len, 100);
    `chk("fcs bits", 576 * CPB, len)
    rd(12'h004, r);
    `chk("carrier lost", 1'b1, r[1])
    `chk("no retry", 0, rew)
    phy.loop_car = 1'b1;
    $display("carrier case done");
    phy.coll_bit = 100;
    start(60);
    measure(len, 0);
    wait (rew == 1);
    phy.coll_bit = 0;
    measure(len, 100);
    `chk("retry bits", 576 * CPB, len)
    rd(12'h004, r);
    `chk("retry flags", 3'b000, r[2:0])
    $display("retry case done");
    phy.coll_bit = 600;
    start(100);
    measure(len, 100);
    phy.coll_bit = 0;
    rd(12'h004, r);
    `chk("late flag", 1'b1, r[2])
    `chk("late no retry", 1, rew)
    `chk("flushed bytes", 100, src_idx)
    $display("late case done");
    phy.coll_bit = 100;
    start(60);
    wait (rew == 16);
    measure(len, 100);
    phy.coll_bit = 0;
    rd(12'h004, r);
    `chk("retry exhausted", 1'b1, r[0])
    `chk("exhausted flushed", 60, src_idx)
    $display("exhausted case done");
    phy.send_rx(20);
    repeat (100 * CPB) @(posedge pclk);
    `chk("runt dropped", 1, drops)
    `chk("runt not ended", 0, ends)
    $display("runt case done");
    wr(12'h000, 32'h73f);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, r);
    `chk("ctrl after reset", 32'h200, r)
    `chk("watermark again", 2'b10, rx_watermark)
    $display("reset case done");
    complete_run();
  end
endmodule
